// [hdl/ccdseq_pkg.sv]
// Purpose: shared constants and types for the readout clock sequencer
// Assumes: 100 MHz system clock
// Notes:   counts derived from times with ceiling rounding
`default_nettype none
package ccdseq_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_PS  = 10000;
	localparam int unsigned SHUT_PULSE_NS  = 1000;  // least substrate pulse width
	localparam int unsigned SHUT_DELAY_NS  = 1000;  // least gap pulse end to first phase
	localparam int unsigned SHUT_PULSE_CYC = (SHUT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned SHUT_DELAY_CYC = (SHUT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned PHASE_CYC      = 4;     // cycles per vertical phase step
	localparam int unsigned PIX_HALF_CYC   = 1;     // cycles per horizontal half period

	// ****************************************
	// frame geometry per readout mode
	// ****************************************
	localparam logic [11:0] LINES_SHORT  = 12'h23C; // 572
	localparam logic [11:0] LINES_LONG   = 12'h478; // 1144
	localparam logic [11:0] PIXELS_SHORT = 12'h3F5; // 1013
	localparam logic [11:0] PIXELS_LONG  = 12'h7EA; // 2026
	localparam int unsigned CNT_W        = 12;
	localparam int unsigned TIMER_W      = 8;

	// vertical phase drive: low, mid, top
	typedef enum logic [1:0] {
		CCDSEQ_LVL_LOW = 2'h0,
		CCDSEQ_LVL_MID = 2'h1,
		CCDSEQ_LVL_TOP = 2'h2
	} ccdseq_lvl_t;

	typedef struct packed {
		ccdseq_lvl_t vertical_phase_one;
		ccdseq_lvl_t vertical_phase_two;
		ccdseq_lvl_t vertical_phase_three;
		ccdseq_lvl_t vertical_phase_four;
	} ccdseq_vert_t;

	typedef struct packed {
		logic phase_one;
		logic horizontal_phase_two_storage;
		logic last_horizontal_gate_clock;
		logic reset_gate;
	} ccdseq_horiz_t;

	// mode 0: short line count, mode 1: long count
	typedef struct packed {
		logic mode_long_lines;
		logic mode_long_pixels;
		logic shutter_enable;
		logic [15:0] exposure_lines;
	} ccdseq_cfg_t;

	typedef enum logic [6:0] {
		CCDSEQ_IDLE  = 7'h01,
		CCDSEQ_SHUT  = 7'h02,
		CCDSEQ_EXPO  = 7'h04,
		CCDSEQ_XFER  = 7'h08,
		CCDSEQ_VLINE = 7'h10,
		CCDSEQ_HPIX  = 7'h20,
		CCDSEQ_DONE  = 7'h40
	} ccdseq_state_t;
endpackage
`default_nettype wire

// [hdl/ccdseq_vpat.sv]
// Purpose: five-step vertical phase pattern generator for one line transfer
// Assumes: start is a one-cycle pulse when idle
// Notes:   rising edges share a cycle with falling edges, except the transfer rise to top, which leads its fall by one step
`timescale 1ns/1ps
`default_nettype none
module ccdseq_vpat (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_start,
	input  wire logic                  i_xfer,
	output ccdseq_pkg::ccdseq_vert_t   o_vert,
	output logic                       o_busy,
	output logic                       o_row_moved
);
	logic [2:0]                          step;
	logic [ccdseq_pkg::TIMER_W-1:0]      timer;
	logic                                xfer_mode;
	ccdseq_pkg::ccdseq_vert_t            next_vert;
	wire logic                           step_end;
	wire logic                           last_step;

	assign step_end  = (timer == ccdseq_pkg::TIMER_W'(ccdseq_pkg::PHASE_CYC - 1));
	assign last_step = (step == 3'h4);

	// pattern table; every change after the transfer rise to top swaps one phase up while another drops together
	always_comb begin
		next_vert = '{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID,
			ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW};
		unique case (step)
			3'h0: next_vert = xfer_mode ?
				'{ccdseq_pkg::CCDSEQ_LVL_TOP, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW} :
				'{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW};
			// top returns to mid exactly as phase four rises
			3'h1: next_vert = '{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_LOW,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_MID};
			// phase one falls here: the row lands in the horizontal register
			3'h2: next_vert = '{ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW,
				ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID};
			3'h3: next_vert = '{ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_LOW};
			// phase one back to mid, ready for the next row
			3'h4: next_vert = '{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW};
			default: next_vert = o_vert;
		endcase
	end

	// step sequencer
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			step        <= 3'h0;
			timer       <= '0;
			o_busy      <= 1'b0;
			xfer_mode   <= 1'b0;
			o_row_moved <= 1'b0;
			o_vert      <= '{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW};
		end else begin
			o_row_moved <= 1'b0;
			if (!o_busy) begin
				if (i_start) begin
					o_busy    <= 1'b1;
					xfer_mode <= i_xfer;
					step      <= 3'h0;
					timer     <= '0;
				end
			end else begin
				o_vert <= next_vert;
				timer  <= step_end ? '0 : timer + 1'b1;
				if (step_end) begin
					step <= step + 3'h1;
					if (last_step) begin
						o_busy      <= 1'b0;
						o_row_moved <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// [hdl/ccdseq_top.sv]
// Purpose: timing generator driving an interline ccd sensor's clock pins
// Assumes: pins are driven through level translators from these codes
// Notes:   horizontal clocks run at half the system clock at fastest
//
// Behaviour
// - each row transfer ends with vertical phase one falling.
// - issue at least 572 or 1144 line transfers per frame by mode.
// - vertical rising edges coincide with or lead the paired falling edge.
// - phase one drops top to mid as phase four rises.
// - toggle last horizontal gate clock once per pixel; sensor shifts on fall.
// - clock at least 1013 or 2026 pixels per line by mode.
// - substrate shutter pulse optional; pin may rest unclocked.
// - exposure runs from shutter fall to next phase one fall.
// - last horizontal gate clock copies horizontal phase two storage waveform.
`timescale 1ns/1ps
`default_nettype none
module ccdseq_top (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_frame_start,
	input  wire ccdseq_pkg::ccdseq_cfg_t i_cfg,
	output ccdseq_pkg::ccdseq_vert_t   o_vert,
	output ccdseq_pkg::ccdseq_horiz_t  o_horiz,
	output logic                       o_substrate_shutter,
	output logic                       o_busy,
	output logic                       o_frame_done,
	output logic                       o_pixel_valid
);
	// ****************************************
	// declarations
	// ****************************************
	ccdseq_pkg::ccdseq_state_t           state;
	ccdseq_pkg::ccdseq_state_t           next_state;
	ccdseq_pkg::ccdseq_cfg_t             cfg;
	logic [ccdseq_pkg::CNT_W-1:0]        line_cnt;
	logic [ccdseq_pkg::CNT_W-1:0]        pix_cnt;
	logic [15:0]                         expo_cnt;
	logic [ccdseq_pkg::TIMER_W-1:0]      timer;
	logic                                hphase;
	logic                                vp_start;
	logic                                vp_xfer;
	logic                                vp_busy;
	logic                                vp_moved;
	ccdseq_pkg::ccdseq_vert_t            vp_vert;
	wire logic [ccdseq_pkg::CNT_W-1:0]   lines_target;
	wire logic [ccdseq_pkg::CNT_W-1:0]   pixels_target;
	wire logic                           shut_done;
	wire logic                           delay_done;
	wire logic                           expo_done;
	wire logic                           line_last;
	wire logic                           pix_last;
	wire logic                           pix_fall;

	// ****************************************
	// decode
	// ****************************************
	function automatic logic timer_hit(input logic [ccdseq_pkg::TIMER_W-1:0] t,
		input int unsigned lim);
		timer_hit = (t >= ccdseq_pkg::TIMER_W'(lim - 1));
	endfunction

	// frame geometry chosen by readout mode
	assign lines_target  = cfg.mode_long_lines ? ccdseq_pkg::LINES_LONG
		: ccdseq_pkg::LINES_SHORT;
	assign pixels_target = cfg.mode_long_pixels ? ccdseq_pkg::PIXELS_LONG
		: ccdseq_pkg::PIXELS_SHORT;
	assign shut_done     = timer_hit(timer, ccdseq_pkg::SHUT_PULSE_CYC);
	assign delay_done    = timer_hit(timer, ccdseq_pkg::SHUT_DELAY_CYC);
	assign expo_done     = delay_done && (expo_cnt >= cfg.exposure_lines);
	assign line_last     = (line_cnt == lines_target - 1'b1);
	assign pix_last      = (pix_cnt == pixels_target - 1'b1);
	assign pix_fall      = hphase && timer_hit(timer, ccdseq_pkg::PIX_HALF_CYC);

	// ****************************************
	// frame state machine
	// ****************************************
	always_comb begin
		next_state = state;
		vp_start   = 1'b0;
		vp_xfer    = 1'b0;
		unique case (state)
			ccdseq_pkg::CCDSEQ_IDLE: if (i_frame_start) begin
				// without shutter the pin rests and exposure is the frame gap
				next_state = i_cfg.shutter_enable ? ccdseq_pkg::CCDSEQ_SHUT
					: ccdseq_pkg::CCDSEQ_XFER;
			end
			ccdseq_pkg::CCDSEQ_SHUT: if (shut_done) begin
				next_state = ccdseq_pkg::CCDSEQ_EXPO;
			end
			// exposure window opens at the shutter fall
			ccdseq_pkg::CCDSEQ_EXPO: if (expo_done) begin
				next_state = ccdseq_pkg::CCDSEQ_XFER;
			end
			// photodiode transfer closes exposure; sensor merges dummy row
			ccdseq_pkg::CCDSEQ_XFER: begin
				vp_start = !vp_busy && !vp_moved;
				vp_xfer  = 1'b1;
				if (vp_moved) begin
					next_state = ccdseq_pkg::CCDSEQ_VLINE;
				end
			end
			ccdseq_pkg::CCDSEQ_VLINE: begin
				vp_start = !vp_busy && !vp_moved;
				if (vp_moved) begin
					next_state = ccdseq_pkg::CCDSEQ_HPIX;
				end
			end
			ccdseq_pkg::CCDSEQ_HPIX: if (pix_fall && pix_last) begin
				next_state = line_last ? ccdseq_pkg::CCDSEQ_DONE
					: ccdseq_pkg::CCDSEQ_VLINE;
			end
			ccdseq_pkg::CCDSEQ_DONE: next_state = ccdseq_pkg::CCDSEQ_IDLE;
			default: next_state = ccdseq_pkg::CCDSEQ_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ccdseq_pkg::CCDSEQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// config latched at frame start so a mode change never splits a frame
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg <= '0;
		end else if (state == ccdseq_pkg::CCDSEQ_IDLE && i_frame_start) begin
			cfg <= i_cfg;
		end
	end

	// ****************************************
	// counters
	// ****************************************
	// shared timer: shutter width, exposure tick, pixel half period
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			timer <= '0;
		end else if (state != next_state) begin
			timer <= '0;
		end else if ((state == ccdseq_pkg::CCDSEQ_EXPO && delay_done)
			|| (state == ccdseq_pkg::CCDSEQ_HPIX
			&& timer_hit(timer, ccdseq_pkg::PIX_HALF_CYC))) begin
			timer <= '0;
		end else begin
			timer <= timer + 1'b1;
		end
	end

	// exposure counted in fixed ticks so each frame matches
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			expo_cnt <= '0;
		end else if (state != ccdseq_pkg::CCDSEQ_EXPO) begin
			expo_cnt <= '0;
		end else if (delay_done) begin
			expo_cnt <= expo_cnt + 16'h0001;
		end
	end

	// line counter, one per completed row
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			line_cnt <= '0;
		end else if (state == ccdseq_pkg::CCDSEQ_XFER) begin
			line_cnt <= '0;
		end else if (state == ccdseq_pkg::CCDSEQ_HPIX && pix_fall && pix_last) begin
			line_cnt <= line_cnt + 1'b1;
		end
	end

	// pixel counter; one horizontal gate fall per pixel
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pix_cnt <= '0;
			hphase  <= 1'b0;
		end else if (state != ccdseq_pkg::CCDSEQ_HPIX) begin
			pix_cnt <= '0;
			hphase  <= 1'b0;
		end else if (timer_hit(timer, ccdseq_pkg::PIX_HALF_CYC)) begin
			hphase  <= !hphase;
			if (hphase) begin
				pix_cnt <= pix_cnt + 1'b1;
			end
		end
	end

	// ****************************************
	// vertical pattern engine
	// ****************************************
	ccdseq_vpat u_vpat (
		.i_clk_sys   (i_clk_sys),
		.i_reset_n   (i_reset_n),
		.i_start     (vp_start),
		.i_xfer      (vp_xfer),
		.o_vert      (vp_vert),
		.o_busy      (vp_busy),
		.o_row_moved (vp_moved)
	);

	// ****************************************
	// pin registers
	// ****************************************
	// storage and last gate clocks share one waveform
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_vert              <= '{ccdseq_pkg::CCDSEQ_LVL_MID, ccdseq_pkg::CCDSEQ_LVL_MID,
				ccdseq_pkg::CCDSEQ_LVL_LOW, ccdseq_pkg::CCDSEQ_LVL_LOW};
			o_horiz             <= '0;
			o_substrate_shutter <= 1'b0;
			o_busy              <= 1'b0;
			o_frame_done        <= 1'b0;
			o_pixel_valid       <= 1'b0;
		end else begin
			o_vert                               <= vp_vert;
			o_horiz.phase_one                    <= !hphase
				&& state == ccdseq_pkg::CCDSEQ_HPIX;
			o_horiz.horizontal_phase_two_storage <= hphase;
			o_horiz.last_horizontal_gate_clock   <= hphase;
			o_horiz.reset_gate                   <= state == ccdseq_pkg::CCDSEQ_HPIX
				&& !hphase && timer == '0;
			o_substrate_shutter <= (state == ccdseq_pkg::CCDSEQ_SHUT);
			o_busy              <= (state != ccdseq_pkg::CCDSEQ_IDLE);
			o_frame_done        <= (state == ccdseq_pkg::CCDSEQ_DONE);
			o_pixel_valid       <= (state == ccdseq_pkg::CCDSEQ_HPIX) && pix_fall;
		end
	end
endmodule
`default_nettype wire

// [verification/ccdseq_asserts.sv]
// Purpose: timing checks on the sequencer pins
// Assumes: cfg held steady for a whole frame
// Notes:   a whole frame is too long to reach in simulation
`timescale 1ns/1ps
`default_nettype none
module ccdseq_asserts (
	input wire logic                      i_clk_sys,
	input wire logic                      i_reset_n,
	input wire logic                      i_frame_start,
	input wire ccdseq_pkg::ccdseq_cfg_t   i_cfg,
	input wire ccdseq_pkg::ccdseq_vert_t  o_vert,
	input wire ccdseq_pkg::ccdseq_horiz_t o_horiz,
	input wire logic                      o_substrate_shutter,
	input wire logic                      o_busy,
	input wire logic                      o_frame_done,
	input wire logic                      o_pixel_valid
);
	// ********
	// helpers
	// ********
	logic [7:0]  p_vert;
	logic [11:0] pix_cnt;
	logic [11:0] line_cnt;
	logic [7:0]  sh_cnt;
	// any phase rising, any phase falling
	function automatic logic [1:0] edges(input logic [7:0] c, input logic [7:0] p);
		edges = 2'h0;
		for (int k = 0; k < 8; k += 2) begin
			if (c[k+:2] > p[k+:2]) edges[1] = 1'b1;
			if (c[k+:2] < p[k+:2]) edges[0] = 1'b1;
		end
	endfunction
	wire logic [1:0]  ed      = edges(o_vert, p_vert);
	wire logic        v1_fall = o_vert[7:6] < p_vert[7:6];
	wire logic [11:0] pix_min = i_cfg.mode_long_pixels ? ccdseq_pkg::PIXELS_LONG
		: ccdseq_pkg::PIXELS_SHORT;
	wire logic [11:0] lin_min = i_cfg.mode_long_lines ? ccdseq_pkg::LINES_LONG
		: ccdseq_pkg::LINES_SHORT;
	// history and counts; reset value of p_vert matches the pins in reset
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			p_vert   <= 8'h50;
			pix_cnt  <= 12'h000;
			line_cnt <= 12'h000;
			sh_cnt   <= 8'h00;
		end else begin
			p_vert   <= o_vert;
			pix_cnt  <= v1_fall ? 12'h000 : pix_cnt + 12'(o_pixel_valid);
			line_cnt <= o_busy ? line_cnt + 12'(v1_fall) : 12'h000;
			sh_cnt   <= o_substrate_shutter ? sh_cnt + 8'h01 : 8'h00;
		end
	end
	// ********
	// properties
	// ********
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	sequence s_top_to_mid;
		o_vert[7:6] == ccdseq_pkg::CCDSEQ_LVL_MID && p_vert[7:6] == ccdseq_pkg::CCDSEQ_LVL_TOP;
	endsequence
	sequence s_taken;
		$past(i_frame_start, 2) || $past(i_frame_start, 3);
	endsequence
	a_gate_copies_storage: assert property (o_horiz.last_horizontal_gate_clock == o_horiz.horizontal_phase_two_storage) else $error("gate clock differs from storage clock");
	a_pixel_on_fall: assert property ($fell(o_horiz.last_horizontal_gate_clock) == $past(o_pixel_valid)) else $error("pixel strobe not one cycle ahead of gate fall");
	a_hclk_phases_oppose: assert property (o_horiz.phase_one |-> !o_horiz.horizontal_phase_two_storage) else $error("horizontal phases overlap");
	a_reset_in_phase: assert property (o_horiz.reset_gate |-> o_horiz.phase_one) else $error("reset gate outside phase one");
	a_pixels_per_line: assert property (v1_fall && pix_cnt != 12'h000 |-> pix_cnt >= pix_min) else $error("too few pixels in a line");
	a_lines_per_frame: assert property (o_frame_done |-> line_cnt >= lin_min) else $error("too few lines in a frame");
	a_top_mid_pair: assert property (s_top_to_mid |-> o_vert[1:0] > p_vert[1:0]) else $error("phase four not rising with phase one drop");
	a_rise_meets_fall: assert property (ed[1] |-> ##[0:4] ed[0]) else $error("vertical rise without paired fall");
	a_row_in_frame: assert property (v1_fall |-> o_busy) else $error("phase one fell outside a frame");
	a_shutter_width: assert property ($fell(o_substrate_shutter) |-> sh_cnt == ccdseq_pkg::SHUT_PULSE_CYC) else $error("shutter pulse width wrong");
	a_shutter_enabled: assert property ($rose(o_substrate_shutter) |-> i_cfg.shutter_enable) else $error("shutter pulse while disabled");
	a_busy_after_take: assert property ($rose(o_busy) |-> s_taken) else $error("busy rose without a request");
endmodule
bind ccdseq_top ccdseq_asserts ccdseq_asserts_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.i_frame_start(i_frame_start), .i_cfg(i_cfg), .o_vert(o_vert), .o_horiz(o_horiz),
	.o_substrate_shutter(o_substrate_shutter), .o_busy(o_busy), .o_frame_done(o_frame_done),
	.o_pixel_valid(o_pixel_valid));
`default_nettype wire

// [verification/ccdseq_sensor.sv]
// Purpose: behavioural sensor that counts charge moves on its clock pins
// Assumes: levels 0 low, 1 mid, 2 top as the sequencer codes them
// Notes:   counts only; no analogue behaviour
`timescale 1ns/1ps
`default_nettype none
module ccdseq_sensor (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_reset_n,
	input  wire ccdseq_pkg::ccdseq_vert_t  i_vert,
	input  wire ccdseq_pkg::ccdseq_horiz_t i_horiz,
	input  wire logic                      i_shutter,
	output var int unsigned                o_rows,
	output var int unsigned                o_line_pix,
	output var int unsigned                o_integ,
	output var int unsigned                o_pulses
);
	int unsigned pix;
	int unsigned t;
	logic        integ_on;
	logic [1:0]  p1;
	logic        pg;
	logic        ps;
	// edges of the pins drive every charge move; sampling on the clock
	// means a glitch shorter than a cycle goes unseen
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{o_rows, o_line_pix, o_integ, o_pulses, pix, t} <= '0;
			{integ_on, pg, ps} <= 3'h0;
			p1 <= 2'h1;
		end else begin
			p1 <= i_vert.vertical_phase_one;
			pg <= i_horiz.last_horizontal_gate_clock;
			ps <= i_shutter;
			if (pg && !i_horiz.last_horizontal_gate_clock) pix <= pix + 1;
			if (!ps && i_shutter) o_pulses <= o_pulses + 1;
			if (ps && !i_shutter) begin
				integ_on <= 1'b1;
				t <= 0;
			end else if (integ_on) t <= t + 1;
			// first move carries the dummy row merged into the dark row
			if (i_vert.vertical_phase_one < p1) begin
				o_rows <= o_rows + 1;
				pix <= 0;
				if (pix != 0) o_line_pix <= pix;
				if (integ_on) o_integ <= t;
				integ_on <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench for the readout sequencer
// Assumes: inputs change 1 ns after the rising edge
// Notes:   each case is cut short after its first line, by a reset or, for the last, by the end of the test
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned N_ROWS = 4;
	localparam int unsigned LIMIT  = 60000; // five cases cut short after one line fit well inside
	typedef struct packed {
		logic        ll;
		logic        lp;
		logic        sh;
		logic [15:0] ex;
		logic [11:0] pix;
	} ccdseq_row_t;
	logic                      i_clk_sys     = 1'b0;
	logic                      i_reset_n     = 1'b0;
	logic                      i_frame_start = 1'b0;
	ccdseq_pkg::ccdseq_cfg_t   i_cfg         = '0;
	ccdseq_pkg::ccdseq_vert_t  o_vert;
	ccdseq_pkg::ccdseq_horiz_t o_horiz;
	logic                      o_substrate_shutter;
	logic                      o_busy;
	logic                      o_frame_done;
	logic                      o_pixel_valid;
	int unsigned               rows, line_pix, integ, pulses;
	int unsigned               bad_count = 0;
	int unsigned               total_checks = 0;
	int unsigned               cyc = 0;
	int unsigned               integ_row [N_ROWS];
	ccdseq_row_t               tab [N_ROWS] = '{
		'{1'b0, 1'b0, 1'b1, 16'h0000, ccdseq_pkg::PIXELS_SHORT},
		'{1'b0, 1'b1, 1'b1, 16'h0002, ccdseq_pkg::PIXELS_LONG},
		'{1'b1, 1'b0, 1'b1, 16'h0002, ccdseq_pkg::PIXELS_SHORT},
		'{1'b1, 1'b1, 1'b0, 16'h0000, ccdseq_pkg::PIXELS_LONG}
	};
	ccdseq_top ccdseq_top_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_frame_start(i_frame_start), .i_cfg(i_cfg), .o_vert(o_vert), .o_horiz(o_horiz),
		.o_substrate_shutter(o_substrate_shutter), .o_busy(o_busy),
		.o_frame_done(o_frame_done), .o_pixel_valid(o_pixel_valid));
	ccdseq_sensor ccdseq_sensor_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_vert(o_vert), .i_horiz(o_horiz), .i_shutter(o_substrate_shutter),
		.o_rows(rows), .o_line_pix(line_pix), .o_integ(integ), .o_pulses(pulses));
	// ********
	// clock, timeout, tasks
	// ********
	always #5 i_clk_sys = ~i_clk_sys;
	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic tick(input int unsigned n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// one-cycle request, then busy seen only after two edges have passed
	task automatic start(input ccdseq_row_t r);
		i_cfg = '{r.ll, r.lp, r.sh, r.ex};
		i_frame_start = 1'b1;
		tick(1);
		i_frame_start = 1'b0;
		cmp_val("busy at take", 1'b0, o_busy);
		tick(2);
		cmp_val("busy after take", 1'b1, o_busy);
	endtask
	task automatic new_frame(input ccdseq_row_t r);
		int unsigned k;
		k = 0;
		i_reset_n = 1'b0;
		tick(2);
		i_reset_n = 1'b1;
		start(r);
		while (line_pix == 0 && k < 20000) begin
			tick(1);
			k++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ********
	// sequence of tests
	// ********
	initial begin
		tick(6);
		cmp_val("vert in reset", 32'h50, o_vert);
		cmp_val("outputs in reset", 6'h00, {o_horiz, o_substrate_shutter, o_busy});
		i_reset_n = 1'b1;
		$display("test reset done");
		// each row resets mid-frame before the next one starts
		for (int r = 0; r < N_ROWS; r++) begin
			new_frame(tab[r]);
			cmp_val("pixels per line", tab[r].pix, line_pix);
			cmp_val("shutter pulses", tab[r].sh, pulses);
			integ_row[r] = integ;
			$display("test row %0d done", r);
		end
		cmp_val("exposure step", 2 * ccdseq_pkg::SHUT_DELAY_CYC, integ_row[1] - integ_row[0]);
		cmp_val("exposure repeat", integ_row[1], integ_row[2]);
		// request while busy must not restart the frame
		new_frame(tab[0]);
		i_frame_start = 1'b1;
		tick(1);
		i_frame_start = 1'b0;
		tick(300);
		cmp_val("pulses after refused", 1, pulses);
		cmp_val("busy after refused", 1'b1, o_busy);
		cmp_val("rows moved", 1'b1, rows >= 2);
		$display("test refused request done");
		end_of_test();
	end
endmodule
`default_nettype wire
